// *** logic/hcb_pkg.sv ***
package hcb_pkg;
  // ----------------------------------------
  // Command codes, bit 7 set means write
  // ----------------------------------------
  localparam logic [7:0] CMD_WRITE_BIT = 8'h80; // Direction flag
  localparam logic [6:0] IDX_ISO_SIZE = 7'h30; // Iso buffer size
  localparam logic [6:0] IDX_DIRECT_LEN = 7'h32; // Direct address and length
  localparam logic [6:0] IDX_ISO_A_PORT = 7'h40; // Iso list A stream port
  localparam logic [6:0] IDX_ISO_B_PORT = 7'h42; // Iso list B stream port
  localparam logic [6:0] IDX_DIRECT_DATA = 7'h45; // Direct data port
  localparam logic [6:0] IDX_TOGGLE_RATE = 7'h47; // Toggle rate

  // ----------------------------------------
  // Field layout and reset values
  // ----------------------------------------
  localparam int ADDR_W = 15; // Buffer start address width
  localparam int DATA_W = 16; // Port word width
  localparam int RATE_W = 4; // Toggle rate field width
  localparam logic [15:0] ISO_SIZE_RST = 16'h0000;
  localparam logic [14:0] START_ADDR_RST = 15'h0000;
  localparam logic [15:0] BYTE_COUNT_RST = 16'h0000;
  localparam logic [3:0] TOGGLE_RATE_RST = 4'h0;
  localparam logic [14:0] STREAM_START = 15'h0000; // Stream ports start here
  localparam logic [15:0] BYTES_PER_WORD = 16'h0002; // One 16-bit word
  localparam logic [14:0] ISO_A_BASE = 15'h0000; // Iso list A at bottom

  // ----------------------------------------
  // Timing and buffering
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100; // 10 MHz system clock
  localparam int MS_NS = 1000000; // One toggle step
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS; // 10000 cycles
  localparam int FIFO_DEPTH = 16; // Write path depth

  // Target of the current command
  typedef enum logic [2:0] {
    T_NONE,
    T_SIZE,
    T_DLEN,
    T_RATE,
    T_DIRECT,
    T_ISOA,
    T_ISOB
  } hcb_tgt_t;
endpackage

// *** logic/hcb_tick.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Millisecond enable divider
// ----------------------------------------
module hcb_tick #(
  parameter int unsigned CYCLES = 10000
) (
  input wire logic sys_clk,
  input wire logic resetn,
  output logic tick
);
  logic [31:0] cnt_r; // Cycles into current period

  // Free running count, one pulse per period
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 32'h00000000;
      tick <= 1'b0;
    end else if (cnt_r == 32'(CYCLES - 1)) begin
      cnt_r <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 32'h00000001;
      tick <= 1'b0;
    end
  end
endmodule // hcb_tick

// *** logic/hcb_fifo.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Write path FIFO, registered flags
// ----------------------------------------
module hcb_fifo #(
  parameter int unsigned WIDTH = 31,
  parameter int unsigned DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage
  logic [AW-1:0] wp_r; // Write pointer
  logic [AW-1:0] rp_r; // Read pointer
  logic [AW:0] cnt_r; // Occupancy
  logic [AW:0] cnt_nxt;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rp_r];

  // Occupancy after this cycle
  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Storage write, no reset needed
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  // Pointers and flags; flags from flops keep ready glitch free
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      in_ready <= (cnt_nxt != (AW+1)'(DEPTH));
      out_valid <= (cnt_nxt != '0);
    end
  end
endmodule // hcb_fifo

// *** logic/hcb_access.sv ***
`timescale 1ns/1ps
// Overview of operation
// R01: Length register upper half holds byte count
// R02: Low 15 bits start address, bit 15 reserved
// R03: Direct port starts at any programmed address
// R04: Codes 32h read, B2h write length register
// R05: Direct data port codes 45h and C5h
// R06: One size register covers both iso buffers
// R07: Iso list A port codes 40h, C0h
// R08: Iso list B port codes 42h, C2h
// R09: Stream ports always start at address zero
// R10: Software loads counter, checks status first
// R11: Software then moves successive data words
// R12: Pointer advances on every stream access
// R13: Count reached raises end-of-transfer, updates status
// R14: Toggle rate 0 to 15 ms, codes 47h/C7h
// R15: Rate in low four bits, upper reserved
// R16: Full bit set while buffer is processed
// R17: Each word advances pointer two bytes
module hcb_access #(
  parameter int unsigned MS_CYCLES = hcb_pkg::MS_CYCLES,
  parameter int unsigned FIFO_DEPTH = hcb_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic wr_stb,
  input wire logic [15:0] wr_data,
  output logic wr_ready,
  input wire logic rd_stb,
  output logic rd_valid,
  output logic [15:0] rd_data,
  input wire logic [15:0] transfer_byte_counter,
  output logic ram_en,
  output logic ram_we,
  output logic [14:0] ram_addr,
  output logic [15:0] ram_wdata,
  input wire logic ram_ready,
  input wire logic ram_rvalid,
  input wire logic [15:0] ram_rdata,
  output logic all_end_of_transfer_flag,
  output logic iso_list_a_full,
  output logic iso_list_b_full,
  output logic iso_list_b_active
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam int FW = hcb_pkg::ADDR_W + hcb_pkg::DATA_W; // Addr plus data

  hcb_pkg::hcb_tgt_t tgt_r; // Current command target
  hcb_pkg::hcb_tgt_t tgt_nxt; // Decoded new target
  logic dir_wr_r; // Current command writes
  logic word_hi_r; // Second half of 32-bit register
  logic [15:0] iso_size_r; // Size of each iso buffer
  logic [14:0] direct_start_address_r; // Direct start
  logic [15:0] direct_byte_count_r; // Direct total bytes
  logic [3:0] toggle_rate_ms_r; // Toggle period in ms
  logic [14:0] ptr_r; // Byte pointer in buffer
  logic [15:0] done_r; // Bytes moved so far
  logic [15:0] limit; // Bytes to move
  logic [15:0] done_nxt; // Bytes after this word
  logic [14:0] base; // Buffer base address
  logic [14:0] acc_addr; // Address of this word
  logic stream; // Target is a data port
  logic acc; // Data word taken
  logic last; // This word ends the transfer
  logic rd_pend_r; // Read waiting for the RAM
  logic [14:0] rd_addr_r; // Address of that read
  logic ram_free; // RAM port can take a request
  logic f_in_ready;
  logic f_out_valid;
  logic [FW-1:0] f_out_data;
  logic ms_tick; // One cycle per millisecond
  logic [3:0] ms_cnt_r; // Milliseconds since toggle
  logic toggle; // Ping-pong swaps now
  logic eot_a_wr; // Write transfer to A ended
  logic eot_b_wr; // Write transfer to B ended

  // ----------------------------------------
  // Command decode
  // ----------------------------------------

  // Low seven bits select the target
  always_comb begin
    case (cmd_code[6:0])
      hcb_pkg::IDX_ISO_SIZE: tgt_nxt = hcb_pkg::T_SIZE; // R06
      hcb_pkg::IDX_DIRECT_LEN: tgt_nxt = hcb_pkg::T_DLEN; // R04
      hcb_pkg::IDX_TOGGLE_RATE: tgt_nxt = hcb_pkg::T_RATE; // R14
      hcb_pkg::IDX_DIRECT_DATA: tgt_nxt = hcb_pkg::T_DIRECT; // R05
      hcb_pkg::IDX_ISO_A_PORT: tgt_nxt = hcb_pkg::T_ISOA; // R07
      hcb_pkg::IDX_ISO_B_PORT: tgt_nxt = hcb_pkg::T_ISOB; // R08
      default: tgt_nxt = hcb_pkg::T_NONE; // Others belong elsewhere
    endcase
  end

  // Data port session and its per-word state
  assign stream = (tgt_r == hcb_pkg::T_DIRECT) || (tgt_r == hcb_pkg::T_ISOA) ||
                  (tgt_r == hcb_pkg::T_ISOB);
  // Reads wait for the previous one to reach the RAM
  assign acc = stream && (dir_wr_r ? (wr_stb && f_in_ready) : (rd_stb && !rd_pend_r));
  // Direct uses its own count, iso ports the shared counter
  assign limit = (tgt_r == hcb_pkg::T_DIRECT) ? direct_byte_count_r :
                 transfer_byte_counter; // R13
  assign done_nxt = done_r + hcb_pkg::BYTES_PER_WORD; // R17
  assign last = done_nxt >= limit; // R13
  // List B sits right after list A, both sized alike
  assign base = (tgt_r == hcb_pkg::T_ISOB) ? iso_size_r[14:0] : hcb_pkg::ISO_A_BASE;
  assign acc_addr = base + ptr_r;
  assign eot_a_wr = acc && last && dir_wr_r && (tgt_r == hcb_pkg::T_ISOA);
  assign eot_b_wr = acc && last && dir_wr_r && (tgt_r == hcb_pkg::T_ISOB);

  // ----------------------------------------
  // Session state
  // ----------------------------------------

  // New command replaces any unfinished one
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tgt_r <= hcb_pkg::T_NONE;
      dir_wr_r <= 1'b0;
    end else if (cmd_valid) begin
      tgt_r <= tgt_nxt;
      dir_wr_r <= cmd_code[7];
    end else if (acc && last) begin
      tgt_r <= hcb_pkg::T_NONE; // R13
    end
  end

  // Pointer starts per port, then steps a word at a time
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ptr_r <= hcb_pkg::STREAM_START;
      done_r <= 16'h0000;
    end else if (cmd_valid) begin
      done_r <= 16'h0000;
      if (tgt_nxt == hcb_pkg::T_DIRECT) begin
        ptr_r <= direct_start_address_r; // R03
      end else begin
        ptr_r <= hcb_pkg::STREAM_START; // R09
      end
    end else if (acc) begin
      ptr_r <= ptr_r + hcb_pkg::BYTES_PER_WORD[14:0]; // R12 R17
      done_r <= done_nxt;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------

  // Writes land on the word strobe after the command
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      iso_size_r <= hcb_pkg::ISO_SIZE_RST;
      direct_start_address_r <= hcb_pkg::START_ADDR_RST;
      direct_byte_count_r <= hcb_pkg::BYTE_COUNT_RST;
      toggle_rate_ms_r <= hcb_pkg::TOGGLE_RATE_RST;
    end else if (wr_stb && dir_wr_r && !cmd_valid) begin
      case (tgt_r)
        hcb_pkg::T_SIZE: begin
          iso_size_r <= wr_data; // R06
        end
        hcb_pkg::T_DLEN: begin
          // Low word first; bit 15 reserved and dropped
          if (!word_hi_r) begin
            direct_start_address_r <= wr_data[14:0]; // R02
          end else begin
            direct_byte_count_r <= wr_data; // R01
          end
        end
        hcb_pkg::T_RATE: begin
          toggle_rate_ms_r <= wr_data[3:0]; // R15
        end
        default: begin
        end
      endcase
    end
  end

  // Half selector of the 32-bit register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      word_hi_r <= 1'b0;
    end else if (cmd_valid) begin
      word_hi_r <= 1'b0;
    end else if (tgt_r == hcb_pkg::T_DLEN && (dir_wr_r ? wr_stb : rd_stb)) begin
      word_hi_r <= !word_hi_r; // R04
    end
  end

  // ----------------------------------------
  // Read answers
  // ----------------------------------------

  // Register reads answer next cycle, buffer reads on RAM return
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_valid <= 1'b0;
      rd_data <= 16'h0000;
    end else begin
      rd_valid <= 1'b0;
      if (ram_rvalid) begin
        rd_valid <= 1'b1;
        rd_data <= ram_rdata;
      end else if (rd_stb && !dir_wr_r && !cmd_valid) begin
        case (tgt_r)
          hcb_pkg::T_SIZE: begin
            rd_valid <= 1'b1;
            rd_data <= iso_size_r; // R06
          end
          hcb_pkg::T_DLEN: begin
            rd_valid <= 1'b1;
            // Reserved bit 15 reads zero
            rd_data <= word_hi_r ? direct_byte_count_r :
                       {1'b0, direct_start_address_r}; // R01 R02
          end
          hcb_pkg::T_RATE: begin
            rd_valid <= 1'b1;
            rd_data <= {12'h000, toggle_rate_ms_r}; // R15
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Read held until the RAM port is free and no write is queued
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_pend_r <= 1'b0;
      rd_addr_r <= 15'h0000;
    end else if (acc && !dir_wr_r) begin
      rd_pend_r <= 1'b1;
      rd_addr_r <= acc_addr; // R12
    end else if (ram_free && !f_out_valid) begin
      rd_pend_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Write buffering and RAM port
  // ----------------------------------------

  // A slow RAM fills the FIFO and stalls the host via wr_ready
  hcb_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .in_valid(acc && dir_wr_r),
    .in_ready(f_in_ready),
    .in_data({acc_addr, wr_data}),
    .out_valid(f_out_valid),
    .out_ready(ram_free),
    .out_data(f_out_data)
  );
  assign wr_ready = f_in_ready;
  assign ram_free = !ram_en || ram_ready;

  // Request held until taken; queued writes go before a read
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ram_en <= 1'b0;
      ram_we <= 1'b0;
      ram_addr <= 15'h0000;
      ram_wdata <= 16'h0000;
    end else if (ram_free) begin
      if (f_out_valid) begin
        ram_en <= 1'b1;
        ram_we <= 1'b1;
        ram_addr <= f_out_data[FW-1:hcb_pkg::DATA_W];
        ram_wdata <= f_out_data[hcb_pkg::DATA_W-1:0];
      end else if (rd_pend_r) begin
        ram_en <= 1'b1;
        ram_we <= 1'b0;
        ram_addr <= rd_addr_r;
      end else begin
        ram_en <= 1'b0;
        ram_we <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // End of transfer and buffer status
  // ----------------------------------------

  // One-cycle pulse to the interrupt unit
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      all_end_of_transfer_flag <= 1'b0;
    end else begin
      all_end_of_transfer_flag <= acc && last; // R13
    end
  end

  // Millisecond enable for the ping-pong
  hcb_tick #(
    .CYCLES(MS_CYCLES)
  ) u_tick (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .tick(ms_tick)
  );

  // Rate zero holds the current buffer; a rate lowered below the
  // count swaps at the next tick rather than wrapping through 15 ms
  assign toggle = ms_tick && (toggle_rate_ms_r != 4'h0) &&
                  (ms_cnt_r + 4'h1 >= toggle_rate_ms_r); // R14

  // Count milliseconds and swap buffers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ms_cnt_r <= 4'h0;
      iso_list_b_active <= 1'b0;
    end else if (toggle) begin
      ms_cnt_r <= 4'h0;
      iso_list_b_active <= !iso_list_b_active; // R14
    end else if (ms_tick && toggle_rate_ms_r != 4'h0) begin
      ms_cnt_r <= ms_cnt_r + 4'h1;
    end
  end

  // Filled buffer is processed until the ping-pong leaves it; set wins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      iso_list_a_full <= 1'b0;
      iso_list_b_full <= 1'b0;
    end else begin
      if (eot_a_wr) begin
        iso_list_a_full <= 1'b1; // R13 R16
      end else if (toggle && !iso_list_b_active) begin
        iso_list_a_full <= 1'b0; // R16
      end
      if (eot_b_wr) begin
        iso_list_b_full <= 1'b1; // R13 R16
      end else if (toggle && iso_list_b_active) begin
        iso_list_b_full <= 1'b0; // R16
      end
    end
  end
endmodule // hcb_access

// *** verification/hcb_access_monitor.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Port checker for the access block
// ----------------------------------------
module hcb_access_monitor (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic wr_ready,
  input wire logic rd_valid,
  input wire logic [15:0] rd_data,
  input wire logic ram_en,
  input wire logic ram_we,
  input wire logic [14:0] ram_addr,
  input wire logic ram_ready,
  input wire logic ram_rvalid,
  input wire logic all_end_of_transfer_flag,
  input wire logic iso_list_a_full,
  input wire logic iso_list_b_full
);
  logic [7:0] last_cmd_r; // Latest command code
  logic [13:0] word_cnt_r; // RAM requests taken since it

  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  // Counts taken requests; valid only once queued writes have drained
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      last_cmd_r <= 8'h00;
      word_cnt_r <= 14'h0000;
    end else if (cmd_valid) begin
      last_cmd_r <= cmd_code;
      word_cnt_r <= 14'h0000;
    end else if (ram_en && ram_ready) begin
      word_cnt_r <= word_cnt_r + 14'h0001;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  reset_out_a: assert property ($past(resetn) == 1'b0 |-> wr_ready && !ram_en
    && !rd_valid && !all_end_of_transfer_flag) else $error("outputs wrong after reset");
  rd_pulse_a: assert property (rd_valid |=> !rd_valid)
    else $error("read answer longer than one cycle");
  eot_pulse_a: assert property (all_end_of_transfer_flag |=> !all_end_of_transfer_flag)
    else $error("end of transfer longer than one cycle");
  ram_hold_a: assert property (ram_en && !ram_ready |=> ram_en && $stable(ram_addr)
    && $stable(ram_we)) else $error("RAM request changed before taken");
  rd_answer_a: assert property (ram_rvalid |=> rd_valid)
    else $error("RAM data not answered next cycle");
  rate_reserved_a: assert property (rd_valid && last_cmd_r == 8'h47
    |-> rd_data[15:4] == 12'h000) else $error("rate upper bits not zero");
  stream_addr_a: assert property (ram_en && ram_ready && (last_cmd_r == 8'hC0
    || last_cmd_r == 8'h40) |-> ram_addr == {word_cnt_r, 1'b0}) else $error("list A address");
  dir_match_a: assert property (ram_en |-> ram_we == last_cmd_r[7])
    else $error("RAM direction differs from command");
  full_eot_a: assert property ($rose(iso_list_a_full) || $rose(iso_list_b_full)
    |-> all_end_of_transfer_flag) else $error("full bit without end of transfer");
endmodule // hcb_access_monitor

bind hcb_access hcb_access_monitor hcb_access_monitor_i (.sys_clk, .resetn, .cmd_valid,
  .cmd_code, .wr_ready, .rd_valid, .rd_data, .ram_en, .ram_we, .ram_addr, .ram_ready,
  .ram_rvalid, .all_end_of_transfer_flag, .iso_list_a_full, .iso_list_b_full);

// *** verification/hcb_ram_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Buffer RAM seen from the access block
// ----------------------------------------
module hcb_ram_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic stall,
  input wire logic ram_en,
  input wire logic ram_we,
  input wire logic [14:0] ram_addr,
  input wire logic [15:0] ram_wdata,
  output logic ram_ready,
  output logic ram_rvalid,
  output logic [15:0] ram_rdata
);
  logic [15:0] mem [0:16383]; // Word store, byte address halved
  logic pend_r; // Read answer due next cycle
  logic [15:0] pdata_r; // Word fetched for it

  // Stall holds requests off so the write FIFO fills up
  assign ram_ready = !stall;

  // Fixed two-cycle read latency; data line flips outside answers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pend_r <= 1'b0;
      pdata_r <= 16'h0000;
      ram_rvalid <= 1'b0;
      ram_rdata <= 16'h0000;
    end else begin
      ram_rvalid <= pend_r;
      ram_rdata <= pend_r ? pdata_r : ~ram_rdata;
      pend_r <= ram_en && ram_ready && !ram_we;
      if (ram_en && ram_ready && !ram_we) begin
        pdata_r <= mem[ram_addr[14:1]];
      end
      if (ram_en && ram_ready && ram_we) begin
        mem[ram_addr[14:1]] <= ram_wdata;
      end
    end
  end
endmodule // hcb_ram_model

// *** verification/hcb_access_tb.sv ***
`timescale 1ns/1ps
module hcb_access_tb;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic wr_stb = 1'b0;
  logic [15:0] wr_data = 16'h0000;
  logic rd_stb = 1'b0;
  logic [15:0] transfer_byte_counter = 16'h0000;
  logic stall = 1'b0; // RAM back-pressure
  logic [15:0] rd_data, ram_wdata, ram_rdata;
  logic [14:0] ram_addr;
  logic wr_ready, rd_valid, ram_en, ram_we, ram_ready, ram_rvalid;
  logic all_end_of_transfer_flag, iso_list_a_full, iso_list_b_full, iso_list_b_active;
  int mismatches = 0;
  int comparisons = 0;

  // Short millisecond so toggling is seen in tens of cycles
  hcb_access #(.MS_CYCLES(10), .FIFO_DEPTH(16)) hcb_access_i (.sys_clk, .resetn,
    .cmd_valid, .cmd_code, .wr_stb, .wr_data, .wr_ready, .rd_stb, .rd_valid, .rd_data,
    .transfer_byte_counter, .ram_en, .ram_we, .ram_addr, .ram_wdata, .ram_ready,
    .ram_rvalid, .ram_rdata, .all_end_of_transfer_flag, .iso_list_a_full,
    .iso_list_b_full, .iso_list_b_active);
  hcb_ram_model hcb_ram_model_i (.sys_clk, .resetn, .stall, .ram_en, .ram_we, .ram_addr,
    .ram_wdata, .ram_ready, .ram_rvalid, .ram_rdata);

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Host cycles
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] code);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_code = code;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
  endtask
  // Waits on a full FIFO rather than losing the word
  task automatic wr(input logic [15:0] d);
    int i;
    @(negedge sys_clk);
    for (i = 0; i < 60 && wr_ready !== 1'b1; i++) begin
      @(negedge sys_clk);
    end
    wr_stb = 1'b1;
    wr_data = d;
    @(negedge sys_clk);
    wr_stb = 1'b0;
  endtask
  task automatic rd(input logic [15:0] exp);
    int i;
    @(negedge sys_clk);
    rd_stb = 1'b1;
    @(negedge sys_clk);
    rd_stb = 1'b0;
    for (i = 0; i < 20 && rd_valid !== 1'b1; i++) begin
      @(negedge sys_clk);
    end
    check({15'h0000, rd_valid}, 16'h0001);
    check(rd_data, exp);
  endtask
  // Refused read: no answer may follow
  task automatic rd_none;
    int i;
    @(negedge sys_clk);
    rd_stb = 1'b1;
    @(negedge sys_clk);
    rd_stb = 1'b0;
    for (i = 0; i < 4; i++) begin
      check({15'h0000, rd_valid}, 16'h0000);
      @(negedge sys_clk);
    end
  endtask
  task automatic wait_eot;
    int i;
    for (i = 0; i < 10 && all_end_of_transfer_flag !== 1'b1; i++) begin
      @(negedge sys_clk);
    end
    check({15'h0000, all_end_of_transfer_flag}, 16'h0001);
  endtask
  // Queued writes must reach RAM before the next command
  task automatic settle;
    int i, q;
    q = 0;
    for (i = 0; i < 80 && q < 4; i++) begin
      @(negedge sys_clk);
      q = (ram_en || rd_valid) ? 0 : q + 1;
    end
  endtask
  task automatic flip(output int n);
    logic v;
    v = iso_list_b_active;
    for (n = 0; n < 90 && iso_list_b_active === v; n++) begin
      @(negedge sys_clk);
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    cmd(8'h30);
    rd(16'h0000);
    cmd(8'h32);
    rd(16'h0000);
    rd(16'h0000);
    cmd(8'h47);
    rd(16'h0000);
    cmd(8'hB0);
    wr(16'h0100);
    rd_none;
    cmd(8'h31);
    rd_none;
    cmd(8'h30);
    rd(16'h0100);
    cmd(8'hB2);
    wr(16'h8010);
    wr(16'h0006);
    cmd(8'h32);
    rd(16'h0010);
    rd(16'h0006);
    cmd(8'hC7);
    wr(16'hFFF5);
    cmd(8'h47);
    rd(16'h0005);
    $display("test registers done");
  endtask
  task automatic t_direct;
    cmd(8'hC5);
    wr(16'hA001);
    wr(16'hA002);
    wr(16'hA003);
    wait_eot;
    settle;
    check(hcb_ram_model_i.mem[8], 16'hA001);
    check(hcb_ram_model_i.mem[10], 16'hA003);
    cmd(8'h45);
    rd(16'hA001);
    rd(16'hA002);
    rd(16'hA003);
    settle;
    $display("test direct port done");
  endtask
  task automatic t_iso;
    transfer_byte_counter = 16'h0004;
    cmd(8'hC0);
    wr(16'hB001);
    wr(16'hB002);
    wait_eot;
    check({15'h0000, iso_list_a_full}, 16'h0001);
    settle;
    check(hcb_ram_model_i.mem[0], 16'hB001);
    check(hcb_ram_model_i.mem[1], 16'hB002);
    cmd(8'h40);
    rd(16'hB001);
    rd(16'hB002);
    settle;
    cmd(8'hC2);
    wr(16'hC001);
    wr(16'hC002);
    wait_eot;
    check({15'h0000, iso_list_b_full}, 16'h0001);
    settle;
    check(hcb_ram_model_i.mem[128], 16'hC001);
    cmd(8'h42);
    rd(16'hC001);
    rd(16'hC002);
    settle;
    $display("test iso ports done");
  endtask
  // Stalled RAM: strobe held up until the FIFO refuses
  task automatic t_fifo;
    int n;
    cmd(8'hB2);
    wr(16'h0200);
    wr(16'h0040);
    stall = 1'b1;
    cmd(8'hC5);
    n = 0;
    wr_stb = 1'b1;
    while (wr_ready === 1'b1 && n < 24) begin
      wr_data = n[15:0];
      n++;
      @(negedge sys_clk);
    end
    wr_stb = 1'b0;
    check({15'h0000, n >= 16 && n <= 17}, 16'h0001);
    stall = 1'b0;
    settle;
    check(hcb_ram_model_i.mem[256], 16'h0000);
    check(hcb_ram_model_i.mem[255 + n], 16'(n - 1));
    $display("test buffering done");
  endtask
  task automatic t_toggle;
    int r, n;
    for (r = 1; r <= 2; r++) begin
      cmd(8'hC7);
      wr(r[15:0]);
      flip(n);
      flip(n);
      check(n[15:0], 16'(r * 10));
    end
    check({14'h0000, iso_list_a_full, iso_list_b_full}, 16'h0000);
    // Rate zero: no swap for the whole wait
    cmd(8'hC7);
    wr(16'h0000);
    flip(n);
    check(n[15:0], 16'h005A);
    $display("test toggle done");
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    resetn = 1'b1;
    t_regs;
    t_direct;
    t_iso;
    t_fifo;
    t_toggle;
    report_and_stop;
  end
  // Whole run needs a few hundred cycles
  initial begin
    #2000000;
    mismatches++;
    report_and_stop;
  end
endmodule // hcb_access_tb
